// [core/low_power_mode_controller.sv]
// Functional notes
// - Converter runs in idle, its interrupt wakes
// - All channel select bits set powers converter down
// - Halt aborts conversion; settle period after resume
// - Breakpoint active in idle, return adjust flag
// - Breakpoint inactive in halt, registers kept
// - Idle clears mask; reset exit sets it
// - Halt clears mask; reset exit sets it
// - Processor clock waits for oscillator stabilization
// - Generator active in idle; select and power bits
// - Halt without osc bit stops all clocks
// - Halt on vco clock clears base select
// - Halt with osc bit keeps oscillator running
// - Watchdog counts in idle, timeout resets
// - Halt stops watchdog clock, clears prescaler
// - Halt honoured only when enable bit set
// - External interrupt wakes either mode unmasked
// - Keypad interrupt wakes either mode unmasked
// - Voltage detector resets device from either mode
// - Serial interface runs idle, frozen in halt
// - SPI frozen in halt, reset exit resets it
// - Timers run idle, frozen in halt
// - Halt stops bus clock without osc bit
//
// The address map and the APB slave port were decided locally.
`include "lpm_params.svh"

module low_power_mode_controller
    import lpm_pkg::*;
#(
    parameter int unsigned OSC_STAB_CYCLES = `LPM_OSC_STAB_CYCLES
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`LPM_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     idle_instr,
    input  wire logic                     halt_instr,
    input  wire logic                     mask_set,
    input  wire logic                     mask_clear,
    input  wire logic                     ext_irq_req,
    input  wire logic                     keypad_irq_req,
    input  wire logic                     converter_irq_req,
    input  wire logic                     converter_cycle_done,
    input  wire logic                     serial_irq_req,
    input  wire logic                     spi_irq_req,
    input  wire logic                     timer_irq_req,
    input  wire logic                     generator_interrupt_out,
    input  wire logic                     breakpoint_enable,
    input  wire logic                     breakpoint_hit,
    input  wire logic                     watchdog_timeout,
    input  wire logic                     lvd_trip,
    output logic                          cpu_clock_en,
    output logic                          bus_clock_en,
    output logic                          osc_en,
    output logic                          pll_en,
    output logic                          base_clock_select,
    output logic                          generator_outputs_en,
    output logic                          watchdog_clock_en,
    output logic                          watchdog_prescaler_clr,
    output logic                          converter_run,
    output logic                          converter_abort,
    output logic                          converter_settle,
    output logic                          breakpoint_active,
    output logic                          break_return_adjust_flag,
    output logic                          serial_run,
    output logic                          spi_run,
    output logic                          spi_reset,
    output logic                          timer_run,
    output logic                          int_mask_flag,
    output logic                          system_reset_req,
    output logic                          wake_pulse
);

    // ==========================================================
    // Constants and state
    localparam logic [`LPM_CNT_W-1:0] STAB_LAST = `LPM_CNT_W'(OSC_STAB_CYCLES - 1);

    state_t s_r;
    state_t s_nxt;

    logic   ext_ok;
    logic   kbd_ok;
    logic   lvd_reset;
    logic   reset_src;
    logic   idle_wake;
    logic   halt_wake;
    logic   wr_go;
    logic   rd_go;
    logic   st_wr;
    logic   osc_run;

    // ==========================================================
    // Wake and reset sources
    always_comb begin
        ext_ok    = ext_irq_req & ~s_r.masks[`LPM_MASK_EXT];
        kbd_ok    = keypad_irq_req & ~s_r.masks[`LPM_MASK_KBD];
        lvd_reset = lvd_trip & s_r.config_bits[`LPM_CFG_LVD_EN]
                    & s_r.config_bits[`LPM_CFG_LVD_RST];
        reset_src = lvd_reset | watchdog_timeout;
        idle_wake = ext_ok | kbd_ok | converter_irq_req | serial_irq_req
                    | spi_irq_req | timer_irq_req | generator_interrupt_out
                    | (breakpoint_hit & breakpoint_enable);
        halt_wake = ext_ok | kbd_ok;
        osc_run   = s_r.config_bits[`LPM_CFG_OSC_RUN];
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt                 = s_r;
        s_nxt.prescaler_clr   = 1'b0;
        s_nxt.converter_abort = 1'b0;
        s_nxt.spi_reset       = 1'b0;
        s_nxt.system_reset    = 1'b0;
        s_nxt.wake            = 1'b0;
        s_nxt.pready          = 1'b0;
        s_nxt.pslverr         = 1'b0;
        s_nxt.prdata          = 32'h0000_0000;

        // Answer one cycle into the access phase; commit at the ready edge
        wr_go = psel & penable & s_r.pready & pwrite;
        rd_go = psel & penable & ~s_r.pready & ~pwrite;
        st_wr = wr_go && paddr == `LPM_OFF_STATUS;

        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            unique case (paddr)
                `LPM_OFF_CONFIG:    s_nxt.prdata = {28'h0, s_r.config_bits};
                `LPM_OFF_PLL_CTRL:  s_nxt.prdata = {30'h0, s_r.pll_bits};
                `LPM_OFF_CONVERTER: s_nxt.prdata = {27'h0, s_r.chsel};
                `LPM_OFF_MASKS:     s_nxt.prdata = {30'h0, s_r.masks};
                `LPM_OFF_STATUS:    s_nxt.prdata = {26'h0, s_r.last_reset_exit, s_r.settle,
                                                    s_r.break_flag, s_r.int_mask_flag,
                                                    2'(s_r.mode)};
                default:            s_nxt.pslverr = 1'b1;
            endcase
            if (!rd_go) begin
                s_nxt.prdata = 32'h0000_0000;
            end
        end
        if (psel && penable && s_r.pready) begin
            s_nxt.pslverr = 1'b0;
        end

        if (wr_go) begin
            unique case (paddr)
                `LPM_OFF_CONFIG:    s_nxt.config_bits = pwdata[3:0];
                `LPM_OFF_PLL_CTRL:  s_nxt.pll_bits    = pwdata[1:0];
                `LPM_OFF_CONVERTER: s_nxt.chsel       = pwdata[`LPM_CHSEL_W-1:0];
                `LPM_OFF_MASKS:     s_nxt.masks       = pwdata[1:0];
                default: ;
            endcase
        end

        // Core mask requests from ordinary instructions
        if (mask_clear) begin
            s_nxt.int_mask_flag = 1'b0;
        end
        if (mask_set) begin
            s_nxt.int_mask_flag = 1'b1;
        end

        // Software clears the break flag by writing one; a new hit wins
        if (st_wr && pwdata[`LPM_ST_BRK_FLAG]) begin
            s_nxt.break_flag = 1'b0;
        end
        if (breakpoint_hit && breakpoint_enable && s_r.mode == MODE_IDLE) begin
            s_nxt.break_flag = 1'b1;
        end

        // Settle flag ends with the first completed conversion cycle
        if (converter_cycle_done) begin
            s_nxt.settle = 1'b0;
        end

        unique case (s_r.mode)
            MODE_RUN: begin
                if (reset_src) begin
                    s_nxt.system_reset    = 1'b1;
                    s_nxt.int_mask_flag   = 1'b1;
                    s_nxt.spi_reset       = 1'b1;
                    s_nxt.last_reset_exit = 1'b1;
                end else if (halt_instr && s_r.config_bits[`LPM_CFG_HALT_EN]) begin
                    s_nxt.mode            = MODE_HALT;
                    s_nxt.int_mask_flag   = 1'b0;
                    s_nxt.converter_abort = 1'b1;
                    s_nxt.prescaler_clr   = 1'b1;
                    s_nxt.pll_bits[`LPM_PLL_BCS] = 1'b0;
                end else if (idle_instr) begin
                    s_nxt.mode          = MODE_IDLE;
                    s_nxt.int_mask_flag = 1'b0;
                end
            end
            MODE_IDLE: begin
                if (reset_src) begin
                    s_nxt.mode            = MODE_RUN;
                    s_nxt.system_reset    = 1'b1;
                    s_nxt.int_mask_flag   = 1'b1;
                    s_nxt.spi_reset       = 1'b1;
                    s_nxt.converter_abort = 1'b1;
                    s_nxt.last_reset_exit = 1'b1;
                    s_nxt.wake            = 1'b1;
                end else if (idle_wake) begin
                    s_nxt.mode            = MODE_RUN;
                    s_nxt.last_reset_exit = 1'b0;
                    s_nxt.wake            = 1'b1;
                end
            end
            MODE_HALT: begin
                // Watchdog is unclocked here, so only the detector can reset
                if (lvd_reset) begin
                    s_nxt.mode          = MODE_RECOVER;
                    s_nxt.stab_cnt      = '0;
                    s_nxt.exit_by_reset = 1'b1;
                    s_nxt.system_reset  = 1'b1;
                end else if (halt_wake) begin
                    s_nxt.mode          = MODE_RECOVER;
                    s_nxt.stab_cnt      = '0;
                    s_nxt.exit_by_reset = 1'b0;
                end
            end
            MODE_RECOVER: begin
                if (s_r.stab_cnt == STAB_LAST) begin
                    s_nxt.mode            = MODE_RUN;
                    s_nxt.wake            = 1'b1;
                    s_nxt.last_reset_exit = s_r.exit_by_reset;
                    if (s_r.exit_by_reset) begin
                        s_nxt.int_mask_flag = 1'b1;
                        s_nxt.spi_reset     = 1'b1;
                    end else if (!(&s_r.chsel)) begin
                        s_nxt.settle = 1'b1;
                    end
                end else begin
                    s_nxt.stab_cnt = s_r.stab_cnt + 1'b1;
                end
            end
        endcase

        // Outputs follow the next mode so that they leave a flop
        s_nxt.cpu_clock_en   = s_nxt.mode inside {MODE_RUN};
        s_nxt.bus_clock_en   = s_nxt.mode inside {MODE_RUN, MODE_IDLE}
                               || (s_nxt.mode == MODE_HALT && osc_run);
        s_nxt.osc_en         = s_nxt.mode != MODE_HALT || osc_run;
        s_nxt.pll_en         = s_nxt.pll_bits[`LPM_PLL_ON]
                               && s_nxt.mode inside {MODE_RUN, MODE_IDLE};
        s_nxt.gen_outputs_en = s_nxt.mode inside {MODE_RUN, MODE_IDLE}
                               || (s_nxt.mode == MODE_HALT && osc_run);
        s_nxt.watchdog_clock_en = s_nxt.mode inside {MODE_RUN, MODE_IDLE};
        s_nxt.converter_run  = !(&s_nxt.chsel)
                               && s_nxt.mode inside {MODE_RUN, MODE_IDLE};
        s_nxt.breakpoint_active = breakpoint_enable
                               && s_nxt.mode inside {MODE_RUN, MODE_IDLE};
        // Frozen peripherals keep their registers; only the clock is withheld
        s_nxt.periph_run     = s_nxt.mode inside {MODE_RUN, MODE_IDLE};
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r                   <= '0;
            s_r.mode              <= MODE_RUN;
            s_r.config_bits       <= `LPM_RST_CONFIG;
            s_r.pll_bits          <= `LPM_RST_PLL;
            s_r.chsel             <= `LPM_RST_CHSEL;
            s_r.masks             <= `LPM_RST_MASKS;
            s_r.int_mask_flag     <= 1'b1;
            s_r.cpu_clock_en      <= 1'b1;
            s_r.bus_clock_en      <= 1'b1;
            s_r.osc_en            <= 1'b1;
            s_r.gen_outputs_en    <= 1'b1;
            s_r.watchdog_clock_en <= 1'b1;
            s_r.periph_run        <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata                   = s_r.prdata;
    assign pready                   = s_r.pready;
    assign pslverr                  = s_r.pslverr;
    assign cpu_clock_en             = s_r.cpu_clock_en;
    assign bus_clock_en             = s_r.bus_clock_en;
    assign osc_en                   = s_r.osc_en;
    assign pll_en                   = s_r.pll_en;
    assign base_clock_select        = s_r.pll_bits[`LPM_PLL_BCS];
    assign generator_outputs_en     = s_r.gen_outputs_en;
    assign watchdog_clock_en        = s_r.watchdog_clock_en;
    assign watchdog_prescaler_clr   = s_r.prescaler_clr;
    assign converter_run            = s_r.converter_run;
    assign converter_abort          = s_r.converter_abort;
    assign converter_settle         = s_r.settle;
    assign breakpoint_active        = s_r.breakpoint_active;
    assign break_return_adjust_flag = s_r.break_flag;
    assign serial_run               = s_r.periph_run;
    assign spi_run                  = s_r.periph_run;
    assign spi_reset                = s_r.spi_reset;
    assign timer_run                = s_r.periph_run;
    assign int_mask_flag            = s_r.int_mask_flag;
    assign system_reset_req         = s_r.system_reset;
    assign wake_pulse               = s_r.wake;

endmodule

// [core/lpm_params.svh]
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ==========================================================
// Register offsets
`define LPM_OFF_CONFIG       12'h000
`define LPM_OFF_PLL_CTRL     12'h004
`define LPM_OFF_CONVERTER    12'h008
`define LPM_OFF_MASKS        12'h00c
`define LPM_OFF_STATUS       12'h010
`define LPM_ADDR_W           12

// ==========================================================
// Field positions
`define LPM_CFG_HALT_EN      0
`define LPM_CFG_OSC_RUN      1
`define LPM_CFG_LVD_EN       2
`define LPM_CFG_LVD_RST      3
`define LPM_PLL_ON           0
`define LPM_PLL_BCS          1
`define LPM_MASK_EXT         0
`define LPM_MASK_KBD         1
`define LPM_ST_MODE_LO       0
`define LPM_ST_IMASK         2
`define LPM_ST_BRK_FLAG      3
`define LPM_ST_SETTLE        4
`define LPM_ST_RST_EXIT      5
`define LPM_CHSEL_W          5

// ==========================================================
// Reset values
`define LPM_RST_CONFIG       4'h0
`define LPM_RST_PLL          2'h0
`define LPM_RST_CHSEL        5'h1f
`define LPM_RST_MASKS        2'h0

// ==========================================================
// Timing
`define LPM_OSC_STAB_CYCLES  4096
`define LPM_CNT_W            13

`endif

// [core/lpm_pkg.sv]
`include "lpm_params.svh"

package lpm_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_HALT,
        MODE_RECOVER
    } mode_t;

    typedef struct packed {
        mode_t                      mode;
        logic [`LPM_CNT_W-1:0]      stab_cnt;
        logic                       exit_by_reset;
        logic [3:0]                 config_bits;
        logic [1:0]                 pll_bits;
        logic [`LPM_CHSEL_W-1:0]    chsel;
        logic [1:0]                 masks;
        logic                       int_mask_flag;
        logic                       break_flag;
        logic                       settle;
        logic                       last_reset_exit;
        logic                       cpu_clock_en;
        logic                       bus_clock_en;
        logic                       osc_en;
        logic                       pll_en;
        logic                       gen_outputs_en;
        logic                       watchdog_clock_en;
        logic                       prescaler_clr;
        logic                       converter_run;
        logic                       converter_abort;
        logic                       breakpoint_active;
        logic                       periph_run;
        logic                       spi_reset;
        logic                       system_reset;
        logic                       wake;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } state_t;

endpackage

// [tb/lpm_chk.sv]
module lpm_chk #(
    parameter int unsigned OSC_STAB_CYCLES = 4096
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic idle_instr,
    input wire logic halt_instr,
    input wire logic watchdog_timeout,
    input wire logic lvd_trip,
    input wire logic cpu_clock_en,
    input wire logic bus_clock_en,
    input wire logic osc_en,
    input wire logic pll_en,
    input wire logic base_clock_select,
    input wire logic generator_outputs_en,
    input wire logic watchdog_clock_en,
    input wire logic watchdog_prescaler_clr,
    input wire logic converter_run,
    input wire logic converter_abort,
    input wire logic serial_run,
    input wire logic spi_run,
    input wire logic timer_run,
    input wire logic breakpoint_active,
    input wire logic int_mask_flag,
    input wire logic system_reset_req,
    input wire logic wake_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // Recovery length, seen as oscillator up with bus gated
    logic [15:0] rc_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_r <= 16'h0;
        end else begin
            rc_r <= (osc_en && !bus_clock_en && !cpu_clock_en) ? rc_r + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ========
    // Checks
    a_idle_entry: assert property (
        idle_instr && cpu_clock_en && !halt_instr && !watchdog_timeout && !lvd_trip
        |=> !cpu_clock_en && !int_mask_flag) else $error("idle entry wrong");
    a_wake_restart: assert property (
        wake_pulse |-> cpu_clock_en && !$past(cpu_clock_en)) else $error("wake wrong");
    a_halt_watchdog: assert property (
        $fell(watchdog_clock_en) |-> watchdog_prescaler_clr && !cpu_clock_en)
        else $error("watchdog not stopped");
    a_halt_pll_off: assert property (
        $fell(watchdog_clock_en) |-> !pll_en && !base_clock_select && !converter_run
        && converter_abort) else $error("halt entry wrong");
    a_halt_bus_osc: assert property (
        $fell(watchdog_clock_en) |-> bus_clock_en == osc_en
        && generator_outputs_en == osc_en) else $error("halt clocks wrong");
    a_halt_frozen: assert property (
        $fell(watchdog_clock_en) |-> !(serial_run || spi_run || timer_run
        || breakpoint_active)) else $error("module runs in halt");
    a_idle_running: assert property (
        $fell(cpu_clock_en) && watchdog_clock_en |-> bus_clock_en && osc_en
        && serial_run && spi_run && timer_run) else $error("module stopped in idle");
    a_wd_reset: assert property (
        watchdog_timeout && watchdog_clock_en && bus_clock_en
        |=> system_reset_req && int_mask_flag) else $error("no watchdog reset");
    a_stab_wait: assert property (
        $rose(cpu_clock_en) && rc_r != 16'h0 |-> rc_r == OSC_STAB_CYCLES)
        else $error("recovery length wrong");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready) else $error("no apb answer");
endmodule

bind low_power_mode_controller lpm_chk #(.OSC_STAB_CYCLES(OSC_STAB_CYCLES)) chk_i (.*);

// [tb/lpm_far_model.sv]
module lpm_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [6:0] raise,
    input  wire logic [3:0] dly,
    input  wire logic       wake_pulse,
    input  wire logic       system_reset_req,
    input  wire logic       converter_settle,
    output logic      [6:0] irq,
    output logic            converter_cycle_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] pend_r;
    logic [3:0] cnt_r;
    logic [3:0] scnt_r;
    // ========
    // Requests held until serviced, after a prompt or slow delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 7'h0;
            pend_r <= 7'h0;
            cnt_r <= 4'h0;
            scnt_r <= 4'h0;
            converter_cycle_done <= 1'b0;
        end else begin
            scnt_r <= converter_settle ? scnt_r + 4'h1 : 4'h0;
            converter_cycle_done <= (scnt_r == 4'h3);
            if (wake_pulse || system_reset_req) begin
                irq <= 7'h0;
                pend_r <= 7'h0;
            end else if (pend_r != 7'h0 && cnt_r >= dly) begin
                irq <= irq | pend_r;
                pend_r <= raise;
                cnt_r <= 4'h0;
            end else begin
                pend_r <= pend_r | raise;
                cnt_r <= (pend_r != 7'h0) ? cnt_r + 4'h1 : 4'h0;
            end
        end
    end
endmodule

// [tb/low_power_mode_controller_test.sv]
module low_power_mode_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STAB = 6;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic idle_instr, halt_instr, mask_set, mask_clear, breakpoint_enable, breakpoint_hit;
    logic watchdog_timeout, lvd_trip, converter_cycle_done, cpu_clock_en, bus_clock_en;
    logic osc_en, pll_en, base_clock_select, generator_outputs_en, watchdog_clock_en;
    logic watchdog_prescaler_clr, converter_run, converter_abort, converter_settle;
    logic breakpoint_active, break_return_adjust_flag, serial_run, spi_run, spi_reset;
    logic timer_run, int_mask_flag, system_reset_req, wake_pulse;
    logic [6:0] raise, irq;
    logic [3:0] dly;
    int error_cnt, n_tests, cyc, i;
    int n[5];
    int exp_n[5] = '{12, 2, 2, 3, 2};
    int rv[5] = '{0, 0, 32'h1f, 0, 4};
    low_power_mode_controller #(.OSC_STAB_CYCLES(STAB)) dut (
        .ext_irq_req            (irq[0]),
        .keypad_irq_req         (irq[1]),
        .converter_irq_req      (irq[2]),
        .serial_irq_req         (irq[3]),
        .spi_irq_req            (irq[4]),
        .timer_irq_req          (irq[5]),
        .generator_interrupt_out(irq[6]),
        .*
    );
    lpm_far_model far (.*);
    wire logic [4:0] pls = {wake_pulse, system_reset_req, spi_reset, converter_abort,
                            watchdog_prescaler_clr};
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ========
    // Pulse counts and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
        foreach (n[k]) if (pls[4-k] === 1'b1) n[k]++;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // Bits: idle, halt, mask set, hit, timeout, low voltage, then requests
    task automatic pulse(input logic [12:0] v);
        @(posedge pclk);
        {idle_instr, halt_instr, mask_set, breakpoint_hit, watchdog_timeout, lvd_trip, raise} <= v;
        @(posedge pclk);
        {idle_instr, halt_instr, mask_set, breakpoint_hit, watchdog_timeout, lvd_trip, raise} <= '0;
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ========
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mask_clear, breakpoint_enable} = 0;
        {idle_instr, halt_instr, mask_set, breakpoint_hit, watchdog_timeout, lvd_trip} = 0;
        {raise, dly} = 0;
        void'($urandom(32'hb9fd));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(int_mask_flag, 1);
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(r, rv[i]);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(r, 32'h0);
        chk(e, 1);
        pulse(13'h0800);
        @(posedge pclk);
        chk({cpu_clock_en, watchdog_clock_en}, 2'h3);
        apb(1'b1, 12'h008, $urandom_range(0, 30));
        for (i = 0; i < 7; i++) begin
            dly <= (i % 2) ? 4'h5 : 4'h0;
            pulse(13'h1000);
            @(posedge pclk);
            chk({cpu_clock_en, int_mask_flag, converter_run, spi_run, timer_run}, 5'h7);
            pulse(13'(1 << i));
            @(posedge pclk iff wake_pulse);
            chk(int_mask_flag, 0);
            repeat (2) @(posedge pclk);
        end
        pulse(13'h0400);
        @(posedge pclk);
        chk(int_mask_flag, 1);
        breakpoint_enable <= 1'b1;
        pulse(13'h1000);
        pulse(13'h0200);
        @(posedge pclk);
        chk({breakpoint_active, break_return_adjust_flag}, 2'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk(r, 32'h8);
        apb(1'b1, 12'h010, 32'h8);
        @(posedge pclk);
        chk(break_return_adjust_flag, 0);
        pulse(13'h0020);
        pulse(13'h1000);
        @(posedge pclk iff wake_pulse);
        pulse(13'h1000);
        pulse(13'h0100);
        @(posedge pclk);
        chk({cpu_clock_en, int_mask_flag}, 2'h3);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b1, 12'h00c, 32'h1);
        pulse(13'h0800);
        @(posedge pclk);
        chk({osc_en, bus_clock_en, generator_outputs_en, pll_en, base_clock_select}, 0);
        chk({watchdog_clock_en, converter_run, serial_run, spi_run, timer_run, breakpoint_active},
            0);
        pulse(13'h0021);
        repeat (8) @(posedge pclk);
        chk(cpu_clock_en, 0);
        pulse(13'h0002);
        @(posedge pclk iff wake_pulse);
        chk({converter_settle, base_clock_select, int_mask_flag, pll_en}, 4'h9);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h1);
        repeat (8) @(posedge pclk);
        chk(converter_settle, 0);
        apb(1'b1, 12'h000, 32'hf);
        pulse(13'h0800);
        @(posedge pclk);
        chk({osc_en, bus_clock_en, pll_en}, 3'h6);
        pulse(13'h0080);
        @(posedge pclk iff wake_pulse);
        chk(int_mask_flag, 1);
        apb(1'b0, 12'h010, 32'h0);
        chk(r, 32'h24);
        apb(1'b1, 12'h008, 32'h1f);
        @(posedge pclk);
        chk(converter_run, 0);
        foreach (n[k]) chk(n[k], exp_n[k]);
        final_report();
    end
endmodule
